/* File: sar_adc_ctrl.sv */
// file: register file, sequencing and result handling of a 12-bit charge-sampled sar converter
`timescale 1ns/10ps
// How it works
// - positive selector, five bits, documented codes
// - negative selector, five bits, others reserved
// - small variant reserves extra selector codes
// - finished conversion sets status bit zero
// - reading result clears status bit zero
// - result lives in bits 27 to 16
// - soft reset write restores defaults, variant strap excepted
// - two six-bit gain codes, at most 32
// - gain calibration ten bits, upper reserved
// - offset calibration ten bits, upper reserved
// - single, differential and pseudo differential modes
// - inputs track, then disconnect at conversion
// - bitwise approximation through all twelve bits
// - pseudo mode: negative switch to reference
// - single software code runs once, returns 000
// - conversions only while enable bit set
module sar_adc_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_comp,
    output logic [31:0] o_rdata,
    output logic [4:0] o_pos_sel,
    output logic [4:0] o_neg_sel,
    output logic [11:0] o_dac_code,
    output logic [11:0] o_amp_gain,
    output logic [9:0] o_gain_cal,
    output logic [9:0] o_offset_cal,
    output sar_adc_pkg::switch_ctrl_t o_sw,
    output logic o_irq
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CONV
    } conv_state_t;

    conv_state_t state_q;
    logic [4:0] pos_q;
    logic [4:0] neg_q;
    logic [7:0] ctrl_q;
    logic [11:0] gain_q;
    logic [9:0] gcal_q;
    logic [9:0] ocal_q;
    logic [11:0] result_q;
    logic [11:0] sar_q;
    logic [3:0] bit_q;
    logic [3:0] acq_q;
    logic [1:0] settle_q;
    logic done_q;
    logic stat_q;
    logic mask_q;
    logic small_q;
    logic comp_meta_q;
    logic comp_q;
    logic soft_rst;
    logic rd_result;
    logic wr_ctrl;
    logic start;
    logic pos_ok;
    logic neg_ok;
    logic [31:0] rdata_d;

    // the comparator is asynchronous to the sar clock
    always_ff @(posedge i_clk) begin
        comp_meta_q <= i_comp;
        comp_q <= comp_meta_q;
    end

    assign soft_rst = i_wr && i_addr == sar_adc_pkg::OFF_SOFT_RST && i_wdata[0];
    assign rd_result = i_rd && i_addr == sar_adc_pkg::OFF_RESULT;
    assign wr_ctrl = i_wr && i_addr == sar_adc_pkg::OFF_CONV_CTRL;

    // ---------------------------------------------------------------
    // selector legality
    // ---------------------------------------------------------------
    // illegal codes are simply not stored; the previous selection stays
    always_comb begin
        pos_ok = i_wdata[4:0] <= sar_adc_pkg::POS_LAST;
        neg_ok = i_wdata[4:0] <= sar_adc_pkg::NEG_LAST;
        if (small_q && i_wdata[4:0] >= sar_adc_pkg::SMALL_RSV_LO
                && i_wdata[4:0] <= sar_adc_pkg::SMALL_RSV_HI) begin
            pos_ok = 1'b0;
            neg_ok = 1'b0;
        end
        if (small_q && (i_wdata[4:0] == sar_adc_pkg::POS_SMALL_RSV_A
                || i_wdata[4:0] == sar_adc_pkg::POS_SMALL_RSV_B)) begin
            pos_ok = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || soft_rst) begin
            pos_q <= sar_adc_pkg::SEL_RST;
            neg_q <= sar_adc_pkg::SEL_RST;
            gain_q <= sar_adc_pkg::GAIN_RST;
            gcal_q <= sar_adc_pkg::CAL_RST;
            ocal_q <= sar_adc_pkg::CAL_RST;
            mask_q <= 1'b0;
        end else if (i_wr) begin
            if (i_addr == sar_adc_pkg::OFF_POS_SEL) begin
                if (pos_ok) begin
                    pos_q <= i_wdata[4:0];
                end
            end else if (i_addr == sar_adc_pkg::OFF_NEG_SEL) begin
                if (neg_ok) begin
                    neg_q <= i_wdata[4:0];
                end
            end else if (i_addr == sar_adc_pkg::OFF_AMP_GAIN) begin
                // out-of-range codes are clipped to the largest legal gain
                gain_q[11:6] <= (i_wdata[11:6] > sar_adc_pkg::GAIN_MAX)
                    ? sar_adc_pkg::GAIN_MAX : i_wdata[11:6];
                gain_q[5:0] <= (i_wdata[5:0] > sar_adc_pkg::GAIN_MAX)
                    ? sar_adc_pkg::GAIN_MAX : i_wdata[5:0];
            end else if (i_addr == sar_adc_pkg::OFF_GAIN_CAL) begin
                gcal_q <= i_wdata[9:0];
            end else if (i_addr == sar_adc_pkg::OFF_OFFS_CAL) begin
                ocal_q <= i_wdata[9:0];
            end else if (i_addr == sar_adc_pkg::OFF_IRQ_MASK) begin
                mask_q <= i_wdata[0];
            end
        end
    end

    // variant strap is software-set so one netlist serves both parts
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            small_q <= 1'b0;
        end else if (i_wr && i_addr == sar_adc_pkg::OFF_VARIANT) begin
            small_q <= i_wdata[0];
        end
    end

    // ---------------------------------------------------------------
    // conversion control
    // ---------------------------------------------------------------
    assign start = ctrl_q[sar_adc_pkg::CTRL_EN_BIT]
        && (ctrl_q[2:0] == sar_adc_pkg::SRC_SINGLE
            || ctrl_q[2:0] == sar_adc_pkg::SRC_CONT);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || soft_rst) begin
            ctrl_q <= sar_adc_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= i_wdata[7:0];
        end else if (done_q && ctrl_q[2:0] == sar_adc_pkg::SRC_SINGLE) begin
            ctrl_q[2:0] <= sar_adc_pkg::SRC_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || soft_rst) begin
            state_q <= ST_IDLE;
            settle_q <= 2'h0;
            sar_q <= 12'h000;
            bit_q <= 4'h0;
            acq_q <= 4'h0;
            done_q <= 1'b0;
            result_q <= 12'h000;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // done_q guard keeps a single shot from restarting
                    if (start && !done_q) begin
                        state_q <= ST_ACQ;
                        acq_q <= 4'h0;
                    end
                end
                ST_ACQ: begin
                    if (!ctrl_q[sar_adc_pkg::CTRL_EN_BIT]) begin
                        state_q <= ST_IDLE;
                    end else if (acq_q == sar_adc_pkg::ACQ_CYCLES - 4'h1) begin
                        state_q <= ST_CONV;
                        sar_q <= 12'h800;
                        bit_q <= 4'h0;
                        settle_q <= 2'h0;
                    end else begin
                        acq_q <= acq_q + 4'h1;
                    end
                end
                ST_CONV: begin
                    // comparator high means the trial overshot: remove the charge step
                    if (!ctrl_q[sar_adc_pkg::CTRL_EN_BIT]) begin
                        state_q <= ST_IDLE;
                    end else if (settle_q != sar_adc_pkg::SETTLE_LAST) begin
                        // a trial passes the dac register, comparator and two sync stages
                        settle_q <= settle_q + 2'h1;
                    end else if (bit_q == sar_adc_pkg::LAST_BIT) begin
                        result_q <= comp_q ? (sar_q & ~(12'h800 >> bit_q)) : sar_q;
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        settle_q <= 2'h0;
                        sar_q <= (comp_q ? (sar_q & ~(12'h800 >> bit_q)) : sar_q)
                            | (12'h800 >> (bit_q + 4'h1));
                        bit_q <= bit_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // status and interrupt
    // ---------------------------------------------------------------
    // completion wins over a same-cycle result read so no result is missed
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || soft_rst) begin
            stat_q <= 1'b0;
        end else if (done_q) begin
            stat_q <= 1'b1;
        end else if (rd_result || (i_wr && i_addr == sar_adc_pkg::OFF_STATUS && i_wdata[0])) begin
            stat_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= stat_q && mask_q;
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_addr == sar_adc_pkg::OFF_POS_SEL) begin
            rdata_d[4:0] = pos_q;
        end else if (i_addr == sar_adc_pkg::OFF_NEG_SEL) begin
            rdata_d[4:0] = neg_q;
        end else if (i_addr == sar_adc_pkg::OFF_STATUS) begin
            rdata_d[0] = stat_q;
        end else if (i_addr == sar_adc_pkg::OFF_RESULT) begin
            rdata_d[27:16] = result_q;
        end else if (i_addr == sar_adc_pkg::OFF_AMP_GAIN) begin
            rdata_d[11:0] = gain_q;
        end else if (i_addr == sar_adc_pkg::OFF_GAIN_CAL) begin
            rdata_d[9:0] = gcal_q;
        end else if (i_addr == sar_adc_pkg::OFF_OFFS_CAL) begin
            rdata_d[9:0] = ocal_q;
        end else if (i_addr == sar_adc_pkg::OFF_CONV_CTRL) begin
            rdata_d[7:0] = ctrl_q;
        end else if (i_addr == sar_adc_pkg::OFF_IRQ_MASK) begin
            rdata_d[0] = mask_q;
        end else if (i_addr == sar_adc_pkg::OFF_VARIANT) begin
            rdata_d[0] = small_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= i_rd ? rdata_d : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // analog-facing outputs
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pos_sel <= sar_adc_pkg::SEL_RST;
            o_neg_sel <= sar_adc_pkg::SEL_RST;
            o_dac_code <= 12'h000;
            o_amp_gain <= sar_adc_pkg::GAIN_RST;
            o_gain_cal <= sar_adc_pkg::CAL_RST;
            o_offset_cal <= sar_adc_pkg::CAL_RST;
            o_sw <= '0;
        end else begin
            o_pos_sel <= pos_q;
            o_neg_sel <= neg_q;
            o_dac_code <= sar_q;
            o_amp_gain <= gain_q;
            o_gain_cal <= gcal_q;
            o_offset_cal <= ocal_q;
            o_sw.track <= state_q == ST_ACQ;
            o_sw.comp_balance <= state_q != ST_CONV;
            // the mode field picks the negative-side switch position
            o_sw.neg_to_ref <= state_q == ST_CONV
                && ctrl_q[4:3] == sar_adc_pkg::MODE_PSEUDO;
            o_sw.neg_to_gnd <= ctrl_q[4:3] == sar_adc_pkg::MODE_SINGLE;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_done_sets_stat: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        done_q |=> stat_q) else $error("status not set after completion");
    a_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        rd_result && !done_q |=> !stat_q) else $error("result read left status set");
    a_result_field: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $past(rd_result) |-> o_rdata[27:16] == $past(result_q) && o_rdata[31:28] == 4'h0)
        else $error("result misplaced");
    a_soft_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        soft_rst |=> gain_q == 12'h000 && ctrl_q == 8'h00 && state_q == ST_IDLE)
        else $error("soft reset incomplete");
    a_gain_limit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        gain_q[11:6] <= 6'h20 && gain_q[5:0] <= 6'h20) else $error("gain above limit");
    a_single_shot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        done_q && ctrl_q[2:0] == 3'h3 && !wr_ctrl && !soft_rst |=> ctrl_q[2:0] == 3'h0)
        else $error("single shot not cleared");
    a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !ctrl_q[7] |=> state_q == ST_IDLE)
        else $error("conversion without enable");
    a_conv_length: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_CONV) |-> ##[47:48] (done_q || state_q == ST_IDLE))
        else $error("conversion length wrong");
    a_first_trial: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(state_q == ST_CONV) |-> sar_q == 12'h800)
        else $error("first trial not mid scale");
    a_conv_switches: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_q == ST_CONV |=> !o_sw.track && !o_sw.comp_balance)
        else $error("inputs connected in conversion");
    a_sample_neg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_q != ST_CONV |=> !o_sw.neg_to_ref)
        else $error("negative switch on reference while sampling");
    a_single_ground: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ctrl_q[4:3] == 2'h0 |=> o_sw.neg_to_gnd)
        else $error("single ended negative side not grounded");
    a_small_rsv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        small_q |-> !(pos_q >= 5'h02 && pos_q <= 5'h05)
            || $past(pos_q) == pos_q || $past(small_q) == 1'b0)
        else $error("reserved code stored");
endmodule // sar_adc_ctrl

/* File: sar_adc_pkg.sv */
// package: register map, field layout, reset values and types of the converter control block
package sar_adc_pkg;
    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_POS_SEL = 8'h00;
    localparam logic [7:0] OFF_NEG_SEL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0c;
    localparam logic [7:0] OFF_SOFT_RST = 8'h10;
    localparam logic [7:0] OFF_AMP_GAIN = 8'h14;
    localparam logic [7:0] OFF_GAIN_CAL = 8'h18;
    localparam logic [7:0] OFF_OFFS_CAL = 8'h1c;
    localparam logic [7:0] OFF_CONV_CTRL = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFF_VARIANT = 8'h28;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int SEL_W = 5;
    localparam int RES_LSB = 16;
    localparam int RES_W = 12;
    localparam int CAL_W = 10;
    localparam int GAIN_W = 6;
    localparam int GAIN0_LSB = 6;
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_MODE_LSB = 3;
    localparam int BITS_W = 4;
    // ---------------------------------------------------------------
    // codes and reset values
    // ---------------------------------------------------------------
    localparam logic [4:0] POS_LAST = 5'h17;
    localparam logic [4:0] NEG_LAST = 5'h10;
    localparam logic [4:0] SMALL_RSV_LO = 5'h02;
    localparam logic [4:0] SMALL_RSV_HI = 5'h05;
    localparam logic [4:0] POS_SMALL_RSV_A = 5'h14;
    localparam logic [4:0] POS_SMALL_RSV_B = 5'h15;
    localparam logic [4:0] POS_GAP_A = 5'h16;
    localparam logic [5:0] GAIN_MAX = 6'h20;
    localparam logic [2:0] SRC_SINGLE = 3'h3;
    localparam logic [2:0] SRC_CONT = 3'h4;
    localparam logic [2:0] SRC_IDLE = 3'h0;
    localparam logic [4:0] SEL_RST = 5'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [11:0] GAIN_RST = 12'h000;
    localparam logic [9:0] CAL_RST = 10'h000;
    localparam logic [3:0] ACQ_CYCLES = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'hb;
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_DIFF = 2'h1,
        MODE_PSEUDO = 2'h2
    } conv_mode_t;

    typedef struct packed {
        logic track;
        logic comp_balance;
        logic neg_to_ref;
        logic neg_to_gnd;
    } switch_ctrl_t;
endpackage

/* File: sar_adc_channel_result_control_test.sv */
// testbench: register, selector, calibration and conversion sequences of the converter control
`timescale 1ns/10ps
module sar_adc_channel_result_control_test;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_comp = 1'b0;
    logic [31:0] o_rdata;
    logic [4:0] o_pos_sel;
    logic [4:0] o_neg_sel;
    logic [11:0] o_dac_code;
    logic [11:0] o_amp_gain;
    logic [9:0] o_gain_cal;
    logic [9:0] o_offset_cal;
    sar_adc_pkg::switch_ctrl_t o_sw;
    logic o_irq;
    int errors = 0;
    int samples_checked = 0;
    logic [4:0] exp_sel;
    logic [7:0] sel_addr;
    logic [7:0] zero_regs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20,
                                    8'h24, 8'h3c};
    logic [31:0] gain_in [4] = '{32'hfffff7df, 32'hffffffff, 32'h0000080a, 32'h00000861};
    logic [11:0] gain_exp [4] = '{12'h7df, 12'h820, 12'h80a, 12'h820};

    always #4 i_clk = ~i_clk;

    sar_adc_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_comp(i_comp), .o_rdata(o_rdata), .o_pos_sel(o_pos_sel),
        .o_neg_sel(o_neg_sel), .o_dac_code(o_dac_code), .o_amp_gain(o_amp_gain),
        .o_gain_cal(o_gain_cal), .o_offset_cal(o_offset_cal), .o_sw(o_sw), .o_irq(o_irq));

    // ---------------------------------------------------------------
    // compare, bus and verdict tasks
    // ---------------------------------------------------------------
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask

    // strobe drops one edge before the next task may raise it again
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
        @(posedge i_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check_data(d, exp, "read data");
    endtask

    task automatic wait_done();
        logic [31:0] d;
        int n;
        d = 32'h0;
        n = 0;
        while (d[0] !== 1'b1 && n < 60) begin
            rd(sar_adc_pkg::OFF_STATUS, d);
            n++;
        end
        check_flag(d[0], 1'b1, "done flag");
    endtask

    function automatic logic sel_ok(input logic v, input logic neg, input logic [4:0] c);
        if (c > (neg ? sar_adc_pkg::NEG_LAST : sar_adc_pkg::POS_LAST)) return 1'b0;
        if (v && c >= sar_adc_pkg::SMALL_RSV_LO && c <= sar_adc_pkg::SMALL_RSV_HI) return 1'b0;
        return !(v && !neg && (c == sar_adc_pkg::POS_SMALL_RSV_A ||
                               c == sar_adc_pkg::POS_SMALL_RSV_B));
    endfunction

    // static comparator: constant answers give all-ones or all-zeros codes whatever the timing
    task automatic conv(input logic [1:0] mode, input logic comp, input logic mask,
                        input logic [11:0] exp);
        logic bal_acq;
        logic ref_acq;
        int n;
        i_comp <= comp;
        wr(sar_adc_pkg::OFF_IRQ_MASK, {31'h0, mask});
        wr(sar_adc_pkg::OFF_CONV_CTRL, {24'h0, 3'b100, mode, sar_adc_pkg::SRC_SINGLE});
        #1;
        bal_acq = 1'b0;
        ref_acq = 1'b1;
        n = 0;
        // the switch outputs are registered: acquisition shows one edge after the start
        while (o_sw.track !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check_flag(o_sw.track, 1'b1, "track in acquisition");
        n = 0;
        while (o_sw.track !== 1'b0 && n < 40) begin
            bal_acq = o_sw.comp_balance;
            ref_acq = o_sw.neg_to_ref;
            @(posedge i_clk);
            #1;
            n++;
        end
        check_flag(o_sw.track, 1'b0, "track");
        check_flag(bal_acq, 1'b1, "balance in acquisition");
        check_flag(o_sw.comp_balance, 1'b0, "balance in conversion");
        check_data({20'h0, o_dac_code}, 32'h800, "first trial");
        check_flag(o_sw.neg_to_gnd, mode == sar_adc_pkg::MODE_SINGLE, "ground");
        if (mode == sar_adc_pkg::MODE_PSEUDO) begin
            check_flag(ref_acq, 1'b0, "negative switch sampling");
            check_flag(o_sw.neg_to_ref, 1'b1, "negative switch converting");
        end
        wait_done();
        check_flag(o_irq, mask, "interrupt");
        rd_chk(sar_adc_pkg::OFF_CONV_CTRL, {24'h0, 3'b100, mode, 3'b000});
        wr(sar_adc_pkg::OFF_RESULT, 32'h0);
        rd_chk(sar_adc_pkg::OFF_RESULT, {4'h0, exp, 16'h0});
        rd_chk(sar_adc_pkg::OFF_STATUS, 32'h0);
        check_flag(o_irq, 1'b0, "interrupt after read");
    endtask

    task automatic finish_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        for (int k = 0; k < 10; k++) rd_chk(zero_regs[k], 32'h0);
        // every code on both variants, reserved upper bits always written as ones
        for (int v = 0; v < 2; v++) begin
            wr(sar_adc_pkg::OFF_VARIANT, v);
            for (int s = 0; s < 2; s++) begin
                sel_addr = s ? sar_adc_pkg::OFF_NEG_SEL : sar_adc_pkg::OFF_POS_SEL;
                wr(sel_addr, 32'h0);
                exp_sel = 5'h00;
                for (int c = 0; c < 32; c++) begin
                    wr(sel_addr, 32'hffffffe0 | c);
                    if (sel_ok(v[0], s[0], c[4:0])) exp_sel = c[4:0];
                    rd_chk(sel_addr, {27'h0, exp_sel});
                    check_data({27'h0, s ? o_neg_sel : o_pos_sel}, {27'h0, exp_sel},
                               "selector");
                end
            end
        end
        wr(sar_adc_pkg::OFF_VARIANT, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(sar_adc_pkg::OFF_AMP_GAIN, gain_in[k]);
            rd_chk(sar_adc_pkg::OFF_AMP_GAIN, {20'h0, gain_exp[k]});
            check_data({20'h0, o_amp_gain}, {20'h0, gain_exp[k]}, "gain");
        end
        wr(sar_adc_pkg::OFF_GAIN_CAL, 32'hffffffff);
        rd_chk(sar_adc_pkg::OFF_GAIN_CAL, 32'h3ff);
        check_data({22'h0, o_gain_cal}, 32'h3ff, "gain cal");
        wr(sar_adc_pkg::OFF_OFFS_CAL, 32'hffff0155);
        rd_chk(sar_adc_pkg::OFF_OFFS_CAL, 32'h155);
        check_data({22'h0, o_offset_cal}, 32'h155, "offset cal");
        // soft reset: a zero write must leave state alone
        wr(sar_adc_pkg::OFF_POS_SEL, 32'h7);
        wr(sar_adc_pkg::OFF_CONV_CTRL, 32'h10);
        wr(sar_adc_pkg::OFF_IRQ_MASK, 32'h1);
        wr(8'h3c, 32'hffffffff);
        wr(sar_adc_pkg::OFF_SOFT_RST, 32'h0);
        rd_chk(sar_adc_pkg::OFF_POS_SEL, 32'h7);
        wr(sar_adc_pkg::OFF_SOFT_RST, 32'h1);
        for (int k = 0; k < 10; k++) rd_chk(zero_regs[k], 32'h0);
        check_data({20'h0, o_amp_gain}, 32'h0, "gain after reset");
        check_data({22'h0, o_offset_cal}, 32'h0, "offset after reset");
        // single shot requested with the enable bit clear
        wr(sar_adc_pkg::OFF_CONV_CTRL, {29'h0, sar_adc_pkg::SRC_SINGLE});
        repeat (60) @(posedge i_clk);
        rd_chk(sar_adc_pkg::OFF_STATUS, 32'h0);
        conv(sar_adc_pkg::MODE_DIFF, 1'b0, 1'b1, 12'hfff);
        conv(sar_adc_pkg::MODE_PSEUDO, 1'b1, 1'b0, 12'h000);
        conv(sar_adc_pkg::MODE_SINGLE, 1'b0, 1'b1, 12'hfff);
        // continuous run, then stop with the source kept and clear by writing one
        i_comp <= 1'b1;
        wr(sar_adc_pkg::OFF_CONV_CTRL, {24'h0, 3'b100, sar_adc_pkg::MODE_DIFF, 3'b100});
        wait_done();
        rd_chk(sar_adc_pkg::OFF_RESULT, 32'h0);
        wait_done();
        wr(sar_adc_pkg::OFF_CONV_CTRL, {29'h0, sar_adc_pkg::SRC_CONT});
        repeat (60) @(posedge i_clk);
        wr(sar_adc_pkg::OFF_STATUS, 32'h1);
        rd_chk(sar_adc_pkg::OFF_STATUS, 32'h0);
        check_flag(o_irq, 1'b0, "interrupt after clear");
        repeat (60) @(posedge i_clk);
        rd_chk(sar_adc_pkg::OFF_STATUS, 32'h0);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        finish_test();
    end
endmodule // sar_adc_channel_result_control_test
